// ---- design/tsl_pkg.sv ----
/*
  Constants for the touch scan, mode and LED control core.
  Assumes a 25 MHz system clock and a sensor front end that delivers ticks on request.
*/
// Contract
// - Sense enabled inputs zero to eleven ascending
// - Processing evaluates results, refreshes pins and status
// - Timer phase idles until next cycle
// - Scan period programmable, separate active and doze
// - Outputs and interrupt updated only in processing; the code also samples digital_input_o every cycle in sleep mode
// - Active mode uses short scan period
// - Doze mode uses longer scan period
// - Sleep mode does no sensor scanning
// - Inactivity timeout moves active to doze, disableable
// - Button touch in doze returns to active
// - Wake sequence required when feature enabled
// - Host may force the operating mode
// - Touch when ticks reach threshold plus hysteresis
// - Release when ticks below threshold minus hysteresis
// - Slider reports combined touched state
// - Slider position by center of gravity
// - Eight independent 256-step PWM generators
// - Log or linear fade, selectable speed, limits
// - Automatic lighting fades on touch and release
// - Host level write starts fade when manual
// - Direct PWM mode outputs host width
// - Pin usable as sampled digital input
// - Position zero at lowest slider index
package tsl_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SCAN_MIN_MS = 15;
  localparam int unsigned ACTIVE_MS = 30;
  localparam int unsigned DOZE_MS = 195;
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  localparam int unsigned NSENS = 12;
  localparam int unsigned NGPIO = 8;
  localparam int unsigned TICK_W = 10;
  localparam logic [11:0] ACTIVE_PER_RST = 12'(ACTIVE_MS);
  localparam logic [11:0] DOZE_PER_RST = 12'(DOZE_MS);
  localparam logic [11:0] SCAN_MIN = 12'(SCAN_MIN_MS);

  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_DOZE = 2'b01,
    MODE_SLEEP = 2'b10
  } tsl_mode_t;

  typedef enum logic [1:0] {
    PH_SENSE = 2'b00,
    PH_PROC = 2'b01,
    PH_TIMER = 2'b10
  } tsl_phase_t;

  typedef enum logic [1:0] {
    GP_LED = 2'b00,
    GP_DIRECT = 2'b01,
    GP_INPUT = 2'b10
  } tsl_gpmode_t;
endpackage : tsl_pkg

// ---- design/tsl_pwm_ch.sv ----
/*
  One LED channel: fader plus 256-step PWM comparator.
  Assumes a shared free-running 8-bit PWM phase and a fade step enable pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module tsl_pwm_ch
  import tsl_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Control
  input wire logic step_i,
  input wire logic on_i,
  input wire logic log_i,
  input wire logic direct_i,
  input wire logic [7:0] direct_width_i,
  input wire logic [7:0] lo_i,
  input wire logic [7:0] hi_i,
  input wire logic [7:0] phase_i,
  // Output
  output logic pwm_o,
  output logic [7:0] level_o
);
  logic [7:0] level_reg;
  logic [7:0] level_next;
  logic [7:0] target;
  logic [7:0] duty;
  logic [15:0] sq;
  logic pwm_reg;

  assign target = on_i ? hi_i : lo_i;
  // Step one count per interval toward target, then hold
  assign level_next = (level_reg < target) ? level_reg + 8'h01 :
                      (level_reg > target) ? level_reg - 8'h01 : level_reg;
  // Square-law approximation of a logarithmic brightness curve
  assign sq = level_reg * level_reg;
  assign duty = direct_i ? direct_width_i : (log_i ? sq[15:8] : level_reg);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg <= 8'h00;
      pwm_reg <= 1'b0;
    end else begin
      if (step_i) begin
        level_reg <= level_next;
      end
      pwm_reg <= (phase_i < duty);
    end
  end

  assign pwm_o = pwm_reg;
  assign level_o = level_reg;

  fade_step_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    step_i && level_reg != target |=> level_reg != $past(level_reg))
    else $error("fade level did not step");
  fade_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !step_i |=> $stable(level_reg))
    else $error("fade level moved without step");
  direct_pwm_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    direct_i && $stable(direct_i) |=> pwm_reg == ($past(phase_i) < $past(direct_width_i)))
    else $error("direct width not followed");
endmodule : tsl_pwm_ch
`default_nettype wire

// ---- design/tsl_button.sv ----
/*
  Touch decision with hysteresis for one sensor.
  Assumes ticks and an update strobe from the processing phase.
*/
`timescale 1ns/100ps
`default_nettype none
module tsl_button
  import tsl_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Evaluation
  input wire logic eval_i,
  input wire logic [TICK_W-1:0] ticks_i,
  input wire logic [TICK_W-1:0] thresh_i,
  input wire logic [TICK_W-1:0] hyst_i,
  // State
  output logic touched_o
);
  logic [TICK_W:0] on_lvl;
  logic [TICK_W:0] off_lvl;
  logic touched_reg;
  logic touched_next;
  logic set_on;
  logic set_off;

  assign on_lvl = {1'b0, thresh_i} + {1'b0, hyst_i};
  assign off_lvl = (thresh_i > hyst_i) ? {1'b0, thresh_i - hyst_i} : '0;
  assign set_on = eval_i && !touched_reg && {1'b0, ticks_i} >= on_lvl;
  assign set_off = eval_i && touched_reg && {1'b0, ticks_i} < off_lvl;
  assign touched_next = set_on || (touched_reg && !set_off);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      touched_reg <= 1'b0;
    end else begin
      touched_reg <= touched_next;
    end
  end

  // Decision visible in the evaluation cycle, so status holds this scan's result
  assign touched_o = touched_next;

  touch_on_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    eval_i && !touched_reg && {1'b0, ticks_i} >= on_lvl |=> touched_reg)
    else $error("touch not detected");
  touch_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    eval_i && touched_reg && {1'b0, ticks_i} >= off_lvl |=> touched_reg)
    else $error("release inside hysteresis band");
endmodule : tsl_button
`default_nettype wire

// ---- design/tsl_core.sv ----
/*
  Scan sequencer, operating mode control, slider and LED control.
  Assumes the analog front end answers each measure request with ticks and a done pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module tsl_core
  import tsl_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC,
  parameter int unsigned SEQ_LEN = 2
)(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Analog sense front end
  output logic sense_req_o,
  output logic [3:0] sense_sel_o,
  input wire logic sense_done_i,
  input wire logic [TICK_W-1:0] sense_ticks_i,
  // Sensor configuration
  input wire logic [NSENS-1:0] sense_enable_i,
  input wire logic [NSENS-1:0] slider_member_i,
  input wire logic [TICK_W-1:0] thresh_i,
  input wire logic [TICK_W-1:0] hyst_i,
  input wire logic [7:0] slider_max_i,
  // Scan and mode control
  input wire logic [11:0] active_period_ms_i,
  input wire logic [11:0] doze_period_ms_i,
  input wire logic [7:0] passive_timeout_i,
  input wire logic operating_mode_force_i,
  input wire logic [1:0] operating_mode_control_i,
  input wire logic wake_seq_enable_i,
  input wire logic [4*SEQ_LEN-1:0] wake_seq_i,
  // GPIO configuration
  input wire logic [2*NGPIO-1:0] gpio_mode_i,
  input wire logic auto_light_enable_i,
  input wire logic [NGPIO-1:0] gpio_output_level_i,
  input wire logic [8*NGPIO-1:0] pwm_direct_width_i,
  input wire logic log_curve_i,
  input wire logic [7:0] fade_interval_i,
  input wire logic [7:0] fade_lo_i,
  input wire logic [7:0] fade_hi_i,
  input wire logic [NGPIO-1:0] gpio_pin_i,
  // Pins and status
  output logic [NGPIO-1:0] gpio_o,
  output logic [NGPIO-1:0] gpio_oe_o,
  output logic [NGPIO-1:0] digital_input_o,
  output logic [NSENS-1:0] button_state_o,
  output logic slider_touched_o,
  output logic [7:0] slider_pos_o,
  output logic [1:0] mode_o,
  output logic [1:0] phase_o,
  output logic interrupt_out_n
);
  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and scan phases
  logic [$clog2(MS_CYCLES+1)-1:0] ms_cnt_reg;
  logic ms_tick;
  tsl_phase_t phase_reg;
  tsl_phase_t phase_next;
  tsl_mode_t mode_reg;
  tsl_mode_t mode_next;
  logic [3:0] idx_reg;
  logic busy_reg;
  logic [11:0] per_cnt_reg;
  logic [11:0] per_sel;
  logic [11:0] per_eff;
  logic period_end;
  logic proc_pulse;
  logic [3:0] next_idx;
  logic found;
  logic [TICK_W-1:0] ticks_reg [NSENS];
  logic [NSENS-1:0] touched;
  logic [NSENS-1:0] eval_vec;

  assign ms_tick = (ms_cnt_reg == ($clog2(MS_CYCLES+1))'(MS_CYCLES - 1));
  assign per_sel = (mode_reg == MODE_DOZE) ? doze_period_ms_i : active_period_ms_i;
  assign per_eff = (per_sel < SCAN_MIN) ? SCAN_MIN : per_sel;
  assign period_end = ms_tick && (per_cnt_reg >= per_eff - 12'h001);

  // Lowest enabled sensor above the current one
  always_comb begin
    next_idx = 4'h0;
    found = 1'b0;
    for (int i = NSENS - 1; i >= 0; i--) begin
      if (sense_enable_i[i] && (i > int'(idx_reg) || !busy_reg)) begin
        next_idx = 4'(i);
        found = 1'b1;
      end
    end
  end

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_SENSE: begin
        if (!busy_reg && !found) phase_next = PH_PROC;
        else if (sense_done_i && !found) phase_next = PH_PROC;
      end
      PH_PROC: phase_next = PH_TIMER;
      PH_TIMER: begin
        if (period_end && mode_reg != MODE_SLEEP) phase_next = PH_SENSE;
      end
      default: phase_next = PH_TIMER;
    endcase
  end
  assign proc_pulse = (phase_reg == PH_PROC);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt_reg <= '0;
      per_cnt_reg <= 12'h000;
      phase_reg <= PH_TIMER;
      idx_reg <= 4'h0;
      busy_reg <= 1'b0;
    end else begin
      ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 1'b1;
      if (period_end) per_cnt_reg <= 12'h000;
      else if (ms_tick) per_cnt_reg <= per_cnt_reg + 12'h001;
      phase_reg <= phase_next;
      if (phase_reg == PH_SENSE) begin
        if (!busy_reg && found) begin
          idx_reg <= next_idx;
          busy_reg <= 1'b1;
        end else if (busy_reg && sense_done_i) begin
          idx_reg <= next_idx;
          busy_reg <= found;
        end
      end else begin
        busy_reg <= 1'b0;
      end
    end
  end

  assign sense_req_o = (phase_reg == PH_SENSE) && busy_reg;
  assign sense_sel_o = idx_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Tick capture and touch decisions
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NSENS; i++) ticks_reg[i] <= '0;
    end else if (sense_req_o && sense_done_i) begin
      ticks_reg[idx_reg] <= sense_ticks_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NSENS; g++) begin : g_btn
      assign eval_vec[g] = proc_pulse && sense_enable_i[g];
      tsl_button u_btn (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .eval_i(eval_vec[g]),
        .ticks_i(ticks_reg[g]),
        .thresh_i(thresh_i),
        .hyst_i(hyst_i),
        .touched_o(touched[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Slider: combined state and center of gravity position
  logic [NSENS-1:0] slider_touch;
  logic [NSENS-1:0] buttons_touch;
  logic [TICK_W+4:0] wsum;
  logic [TICK_W+8:0] msum;
  logic [3:0] nmem;
  logic [3:0] rank;
  logic [TICK_W+16:0] pos_num;
  logic [TICK_W+16:0] pos_den;
  logic [7:0] pos_calc;

  assign slider_touch = touched & slider_member_i & sense_enable_i;
  assign buttons_touch = touched & ~slider_member_i & sense_enable_i;

  always_comb begin
    wsum = '0;
    msum = '0;
    rank = 4'h0;
    nmem = 4'h0;
    for (int i = 0; i < NSENS; i++) begin
      if (slider_member_i[i] && sense_enable_i[i]) begin
        // Rank from lowest member index, so position zero sits there
        wsum = wsum + (TICK_W+5)'(ticks_reg[i]);
        msum = msum + (TICK_W+9)'(ticks_reg[i]) * (TICK_W+9)'(rank);
        rank = rank + 4'h1;
        nmem = nmem + 4'h1;
      end
    end
  end
  assign pos_num = (TICK_W+17)'(msum) * (TICK_W+17)'(slider_max_i);
  assign pos_den = (TICK_W+17)'(wsum) * (TICK_W+17)'((nmem > 4'h1) ? nmem - 4'h1 : 4'h1);
  assign pos_calc = (wsum == '0) ? 8'h00 : 8'(pos_num / pos_den);

  ////////////////////////////////////////////////////////////////////////////////
  // Operating mode: inactivity timeout, wake, wake sequence, host force
  logic [7:0] idle_cnt_reg;
  logic [$clog2(SEQ_LEN+1)-1:0] seq_pos_reg;
  logic [3:0] seq_btn_reg;
  logic seq_hold_reg;
  logic [NSENS-1:0] prev_touch_reg;
  logic [NSENS-1:0] released;
  logic [3:0] exp_btn;
  logic seq_done;
  logic any_touch;

  assign any_touch = |(touched & sense_enable_i);
  assign released = prev_touch_reg & ~buttons_touch;
  assign exp_btn = wake_seq_i[4*seq_pos_reg +: 4];
  assign seq_done = proc_pulse && buttons_touch[exp_btn] == 1'b0 && released[exp_btn]
                    && (seq_pos_reg == ($clog2(SEQ_LEN+1))'(SEQ_LEN - 1));

  always_comb begin
    mode_next = mode_reg;
    if (operating_mode_force_i) begin
      case (operating_mode_control_i)
        2'b01: mode_next = MODE_DOZE;
        2'b10: mode_next = MODE_SLEEP;
        default: mode_next = MODE_ACTIVE;
      endcase
    end else if (proc_pulse) begin
      case (mode_reg)
        MODE_ACTIVE: begin
          if (passive_timeout_i != 8'h00 && !any_touch && idle_cnt_reg >= passive_timeout_i)
            mode_next = MODE_DOZE;
        end
        MODE_DOZE: begin
          if (!wake_seq_enable_i && |buttons_touch) mode_next = MODE_ACTIVE;
          else if (wake_seq_enable_i && seq_done) mode_next = MODE_ACTIVE;
        end
        default: mode_next = mode_reg;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= MODE_ACTIVE;
      idle_cnt_reg <= 8'h00;
      seq_pos_reg <= '0;
      prev_touch_reg <= '0;
    end else begin
      mode_reg <= mode_next;
      if (proc_pulse) begin
        prev_touch_reg <= buttons_touch;
        // Idle measured in scan cycles without touch
        if (any_touch || mode_reg != MODE_ACTIVE) idle_cnt_reg <= 8'h00;
        else if (idle_cnt_reg != 8'hff) idle_cnt_reg <= idle_cnt_reg + 8'h01;
        if (mode_reg != MODE_DOZE || seq_done) seq_pos_reg <= '0;
        else if (released[exp_btn]) seq_pos_reg <= seq_pos_reg + 1'b1;
        else if (|released) seq_pos_reg <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // LED fading and PWM
  logic [7:0] pwm_phase_reg;
  logic [7:0] fade_cnt_reg;
  logic fade_step;
  logic [NGPIO-1:0] led_on;
  logic [NGPIO-1:0] is_direct;
  logic [NGPIO-1:0] is_input;
  logic [NGPIO-1:0] pwm_raw;
  logic [NGPIO-1:0] led_req_reg;
  logic [NGPIO-1:0] din_reg;

  assign fade_step = ms_tick && (fade_cnt_reg >= fade_interval_i);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_phase_reg <= 8'h00;
      fade_cnt_reg <= 8'h00;
    end else begin
      pwm_phase_reg <= pwm_phase_reg + 8'h01;
      if (fade_step) fade_cnt_reg <= 8'h00;
      else if (ms_tick) fade_cnt_reg <= fade_cnt_reg + 8'h01;
    end
  end

  generate
    for (g = 0; g < NGPIO; g++) begin : g_led
      assign is_direct[g] = (gpio_mode_i[2*g +: 2] == GP_DIRECT);
      assign is_input[g] = (gpio_mode_i[2*g +: 2] == GP_INPUT);
      // Automatic lighting follows the mapped sensor, else the host level
      assign led_on[g] = auto_light_enable_i ? touched[g] : gpio_output_level_i[g];
      tsl_pwm_ch u_ch (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .step_i(fade_step),
        .on_i(led_req_reg[g]),
        .log_i(log_curve_i),
        .direct_i(is_direct[g]),
        .direct_width_i(pwm_direct_width_i[8*g +: 8]),
        .lo_i(fade_lo_i),
        .hi_i(fade_hi_i),
        .phase_i(pwm_phase_reg),
        .pwm_o(pwm_raw[g]),
        .level_o()
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Status refresh in the processing phase; digital inputs are also sampled every cycle in sleep
  logic [NSENS-1:0] status_reg;
  logic slider_on_reg;
  logic [7:0] pos_reg;
  logic int_n_reg;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_reg <= '0;
      slider_on_reg <= 1'b0;
      pos_reg <= 8'h00;
      int_n_reg <= 1'b1;
      led_req_reg <= '0;
      din_reg <= '0;
    end else if (proc_pulse) begin
      status_reg <= touched & sense_enable_i;
      slider_on_reg <= |slider_touch;
      if (|slider_touch) pos_reg <= pos_calc;
      led_req_reg <= led_on;
      din_reg <= gpio_pin_i & is_input;
      int_n_reg <= !((touched & sense_enable_i) != status_reg
                     || (gpio_pin_i & is_input) != din_reg);
    end else if (mode_reg == MODE_SLEEP) begin
      din_reg <= gpio_pin_i & is_input;
    end
  end

  assign gpio_o = pwm_raw & ~is_input;
  assign gpio_oe_o = ~is_input;
  assign digital_input_o = din_reg;
  assign button_state_o = status_reg;
  assign slider_touched_o = slider_on_reg;
  assign slider_pos_o = pos_reg;
  assign mode_o = mode_reg;
  assign phase_o = phase_reg;
  assign interrupt_out_n = int_n_reg;

  status_only_proc_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !proc_pulse && mode_reg != MODE_SLEEP |=> $stable(int_n_reg) && $stable(status_reg))
    else $error("status changed outside processing");
  sleep_no_scan_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_reg == MODE_SLEEP && phase_reg == PH_TIMER |=> phase_reg != PH_SENSE)
    else $error("scan started in sleep");
  proc_then_timer_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    phase_reg == PH_PROC |=> phase_reg == PH_TIMER)
    else $error("processing not followed by timer");
  sense_order_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sense_req_o && sense_done_i && found |=> idx_reg > $past(idx_reg))
    else $error("sensor order not ascending");
  force_mode_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    operating_mode_force_i && operating_mode_control_i == 2'b10 |=> mode_reg == MODE_SLEEP)
    else $error("forced sleep not taken");
  doze_wake_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !operating_mode_force_i && proc_pulse && mode_reg == MODE_DOZE && !wake_seq_enable_i
    && |buttons_touch |=> mode_reg == MODE_ACTIVE)
    else $error("touch did not wake from doze");
  timeout_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !operating_mode_force_i && passive_timeout_i == 8'h00 && mode_reg == MODE_ACTIVE
    |=> mode_reg == MODE_ACTIVE)
    else $error("doze entered with timeout disabled");
endmodule : tsl_core
`default_nettype wire

// ---- tb/tsl_afe_model.sv ----
/*
  Front end model: answers each measure request with ticks from a table.
  Assumes one request at a time, held by the core until the done pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module tsl_afe_model
  import tsl_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Request from the core
  input wire logic sense_req_i,
  input wire logic [3:0] sense_sel_i,
  // Stimulus
  input wire logic [NSENS*TICK_W-1:0] ticks_tab_i,
  input wire logic slow_i,
  // Answer
  output logic sense_done_o,
  output logic [TICK_W-1:0] sense_ticks_o
);
  logic [3:0] wait_reg;
  // Ticks outside a done pulse are scrambled so nothing leans on stale data
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg <= 4'h0;
      sense_done_o <= 1'b0;
      sense_ticks_o <= 10'h000;
    end else begin
      sense_done_o <= 1'b0;
      sense_ticks_o <= ~sense_ticks_o;
      if (!sense_req_i || sense_done_o) begin
        wait_reg <= slow_i ? 4'h9 : 4'h1;
      end else if (wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end else begin
        sense_done_o <= 1'b1;
        sense_ticks_o <= ticks_tab_i[sense_sel_i*TICK_W +: TICK_W];
      end
    end
  end
endmodule : tsl_afe_model
`default_nettype wire

// ---- tb/touch_scan_mode_led_control_tb.sv ----
/*
  Self-checking bench for the touch scan, mode and LED core.
  Assumes the front end model and a shortened millisecond of 20 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module touch_scan_mode_led_control_tb
  import tsl_pkg::*;
;
  typedef struct packed {
    logic [9:0] bt;
    logic [9:0] lt;
    logic [9:0] ht;
    logic [5:0] eb;
    logic es;
    logic [7:0] ep;
    logic ei;
  } tsl_row_t;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic slow = 1'b0;
  logic [119:0] tt = '0;
  logic [3:0] esel = 4'h0;
  logic sense_req_o, sense_done_i, slider_touched_o, interrupt_out_n;
  logic [3:0] sense_sel_o;
  logic [TICK_W-1:0] sense_ticks_i;
  logic [NSENS-1:0] sense_enable_i = 12'hfff;
  logic [NSENS-1:0] slider_member_i = 12'hfc0;
  logic [TICK_W-1:0] thresh_i = 10'h064;
  logic [TICK_W-1:0] hyst_i = 10'h00a;
  logic [7:0] slider_max_i = 8'h64;
  logic [11:0] active_period_ms_i = 12'h00a;
  logic [11:0] doze_period_ms_i = 12'h014;
  logic [7:0] passive_timeout_i = 8'h00;
  logic operating_mode_force_i = 1'b0;
  logic [1:0] operating_mode_control_i = 2'b00;
  logic wake_seq_enable_i = 1'b0;
  logic [7:0] wake_seq_i = 8'h21;
  logic [15:0] gpio_mode_i = 16'h0024;
  logic auto_light_enable_i = 1'b1;
  logic [7:0] gpio_output_level_i = 8'h00;
  logic [63:0] pwm_direct_width_i = 64'h0000_0000_0000_4000;
  logic log_curve_i = 1'b0;
  logic [7:0] fade_interval_i = 8'h00;
  logic [7:0] fade_lo_i = 8'h00;
  logic [7:0] fade_hi_i = 8'h80;
  logic [7:0] gpio_pin_i = 8'h00;
  logic [7:0] gpio_o, gpio_oe_o, digital_input_o, slider_pos_o;
  logic [NSENS-1:0] button_state_o;
  logic [1:0] mode_o, phase_o;
  int mismatches = 0;
  int total_checks = 0;
  int n;
  tsl_row_t rows [6] = '{
    '{10'h06d, 10'h000, 10'h000, 6'h00, 1'b0, 8'h00, 1'b1},
    '{10'h06e, 10'h0c8, 10'h000, 6'h3f, 1'b1, 8'h00, 1'b0},
    '{10'h05a, 10'h000, 10'h0c8, 6'h3f, 1'b1, 8'h64, 1'b0},
    '{10'h059, 10'h0c8, 10'h0c8, 6'h00, 1'b1, 8'h32, 1'b0},
    '{10'h069, 10'h000, 10'h000, 6'h00, 1'b0, 8'h00, 1'b0},
    '{10'h069, 10'h000, 10'h000, 6'h00, 1'b0, 8'h00, 1'b1}};
  always #20 clock_i = ~clock_i;
  tsl_core #(.MS_CYCLES(20)) dut (.clock_i, .rst_n_i, .sense_req_o, .sense_sel_o,
    .sense_done_i, .sense_ticks_i, .sense_enable_i, .slider_member_i, .thresh_i, .hyst_i,
    .slider_max_i, .active_period_ms_i, .doze_period_ms_i, .passive_timeout_i,
    .operating_mode_force_i, .operating_mode_control_i, .wake_seq_enable_i, .wake_seq_i,
    .gpio_mode_i, .auto_light_enable_i, .gpio_output_level_i, .pwm_direct_width_i,
    .log_curve_i, .fade_interval_i, .fade_lo_i, .fade_hi_i, .gpio_pin_i, .gpio_o,
    .gpio_oe_o, .digital_input_o, .button_state_o, .slider_touched_o, .slider_pos_o,
    .mode_o, .phase_o, .interrupt_out_n);
  tsl_afe_model afe (.clock_i, .rst_n_i, .sense_req_i(sense_req_o),
    .sense_sel_i(sense_sel_o), .ticks_tab_i(tt), .slow_i(slow),
    .sense_done_o(sense_done_i), .sense_ticks_o(sense_ticks_i));
  ////////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tick(input int c);
    repeat (c) @(posedge clock_i);
    #2;
  endtask : tick
  task automatic wait_phase(input logic [1:0] p, output int c);
    c = 0;
    while (phase_o !== p) begin
      tick(1);
      c++;
      if (c > 3000) begin
        mismatches++;
        stop_test();
      end
    end
  endtask : wait_phase
  task automatic scan();
    wait_phase(PH_PROC, n);
    wait_phase(PH_TIMER, n);
  endtask : scan
  task automatic period(input logic [15:0] exp);
    int a;
    int b;
    wait_phase(PH_SENSE, a);
    wait_phase(PH_TIMER, a);
    wait_phase(PH_SENSE, b);
    check("period", 16'(a + b), exp);
  endtask : period
  task automatic set_t(input logic [5:0] bm, input logic [9:0] b, input logic [9:0] l,
                       input logic [9:0] h);
    tt = '0;
    for (int i = 0; i < 6; i++) begin
      if (bm[i]) tt[i*10 +: 10] = b;
    end
    tt[60 +: 10] = l;
    tt[110 +: 10] = h;
  endtask : set_t
  task automatic duty(input int k, input logic [7:0] w);
    logic [15:0] c;
    c = 16'h0000;
    repeat (256) begin
      tick(1);
      c = c + 16'(gpio_o[k]);
    end
    check("duty", c, 16'(w));
  endtask : duty
  task automatic do_reset();
    rst_n_i = 1'b0;
    tick(10);
    check("mode", 16'(mode_o), 16'(MODE_ACTIVE));
    check("phase", 16'(phase_o), 16'(PH_TIMER));
    check("irq", 16'(interrupt_out_n), 16'h0001);
    check("pins", 16'(gpio_o), 16'h0000);
    check("buttons", 16'(button_state_o), 16'h0000);
    rst_n_i = 1'b1;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////////////
  // Each done in a scan must carry the next index
  always @(negedge clock_i) begin
    if (phase_o === PH_PROC) esel = 4'h0;
    if (sense_req_o === 1'b1 && sense_done_i === 1'b1) begin
      check("sel", 16'(sense_sel_o), 16'(esel));
      esel = esel + 4'h1;
    end
  end
  initial begin
    do_reset();
    for (int r = 0; r < 6; r++) begin
      set_t(6'h3f, rows[r].bt, rows[r].lt, rows[r].ht);
      scan();
      check("buttons", 16'(button_state_o[5:0]), 16'(rows[r].eb));
      check("slider", 16'(slider_touched_o), 16'(rows[r].es));
      if (rows[r].es) begin
        check("pos", 16'(slider_pos_o), 16'(rows[r].ep));
      end
      check("irq", 16'(interrupt_out_n), 16'(rows[r].ei));
    end
    check("mode", 16'(mode_o), 16'(MODE_ACTIVE));
    period(16'h012c);
    set_t(6'h3f, 10'h06e, 10'h000, 10'h000);
    tick(3500);
    duty(0, 8'h80);
    duty(1, 8'h40);
    check("oe", 16'(gpio_oe_o[2]), 16'h0000);
    set_t(6'h00, 10'h000, 10'h000, 10'h000);
    tick(3500);
    duty(0, 8'h00);
    auto_light_enable_i = 1'b0;
    gpio_output_level_i = 8'h08;
    tick(3500);
    duty(3, 8'h80);
    log_curve_i = 1'b1;
    tick(20);
    duty(3, 8'h40);
    scan();
    gpio_pin_i = 8'h04;
    tick(20);
    check("din", 16'(digital_input_o[2]), 16'h0000);
    scan();
    check("din", 16'(digital_input_o[2]), 16'h0001);
    slow = 1'b1;
    passive_timeout_i = 8'h03;
    repeat (6) scan();
    check("mode", 16'(mode_o), 16'(MODE_DOZE));
    period(16'h0190);
    set_t(6'h3f, 10'h06e, 10'h000, 10'h000);
    repeat (2) scan();
    check("mode", 16'(mode_o), 16'(MODE_ACTIVE));
    set_t(6'h00, 10'h000, 10'h000, 10'h000);
    wake_seq_enable_i = 1'b1;
    repeat (6) scan();
    check("mode", 16'(mode_o), 16'(MODE_DOZE));
    set_t(6'h01, 10'h06e, 10'h000, 10'h000);
    scan();
    set_t(6'h00, 10'h000, 10'h000, 10'h000);
    repeat (2) scan();
    check("mode", 16'(mode_o), 16'(MODE_DOZE));
    for (int k = 1; k < 3; k++) begin
      set_t(6'(1 << k), 10'h06e, 10'h000, 10'h000);
      scan();
      set_t(6'h00, 10'h000, 10'h000, 10'h000);
      scan();
    end
    scan();
    check("mode", 16'(mode_o), 16'(MODE_ACTIVE));
    operating_mode_force_i = 1'b1;
    operating_mode_control_i = 2'b10;
    tick(900);
    check("mode", 16'(mode_o), 16'(MODE_SLEEP));
    n = 0;
    repeat (1000) begin
      tick(1);
      if (sense_req_o !== 1'b0 || phase_o !== PH_TIMER) n++;
    end
    check("sleep", 16'(n), 16'h0000);
    gpio_pin_i = 8'h00;
    tick(400);
    check("din", 16'(digital_input_o[2]), 16'h0000);
    operating_mode_control_i = 2'b01;
    tick(900);
    check("mode", 16'(mode_o), 16'(MODE_DOZE));
    operating_mode_control_i = 2'b00;
    tick(900);
    check("mode", 16'(mode_o), 16'(MODE_ACTIVE));
    do_reset();
    stop_test();
  end
endmodule : touch_scan_mode_led_control_tb
`default_nettype wire
